//--- logic/loopback_prbs_pkg.sv
package loopback_prbs_pkg;
    localparam int CHANNELS = 8;
    localparam int WORD_W = 10;
    localparam int LFSR_W = 7;
    localparam logic [6:0] LFSR_SEED = 7'h7F;
    localparam int TAP_HI = 6;
    localparam int TAP_LO = 5;
    // byte addresses of the registers on the bus
    localparam logic [7:0] ADDR_LOOPBACK = 8'h58;
    localparam logic [7:0] ADDR_GLOBAL = 8'h60;
    localparam logic [7:0] ADDR_PASS = 8'h7C;
    // field positions
    localparam int SLB_LSB = 8;
    localparam int FAR_LSB = 0;
    localparam int VERIFY_BIT = 9;
    localparam int GEN_BIT = 8;
    localparam int RX_PASS_LSB = 8;
    localparam logic [15:0] LOOPBACK_RESET = 16'h0000;
    localparam logic [15:0] GLOBAL_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // power-on hold: 1 ms at 20 MHz
    localparam int CLK_HZ = 20000000;
    localparam int POR_US = 1000;
    localparam int POR_CYCLES = POR_US * (CLK_HZ / 1000000);
    localparam int LOCK_GOOD = 16;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic clk_out;
        logic oe;
    } par_out_t;

    typedef struct packed {
        logic p;
        logic n;
    } diff_t;
endpackage

//--- logic/loopback_prbs_test.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
//Contract
// - loopback pin loops all channels serially
// - per-channel serial loopback register bits
// - serial loopback holds transmit output static
// - serial loopback ignores serial receive input
// - far-end loopback per pair via bits
// - far-end loopback ignores parallel transmit data
// - far-end loopback floats parallel outputs
// - power-on reset floats data, clock low
// - power-on reset lasts about 1 ms
// - pattern generator and checker per channel
// - pattern test by pin or bit
// - pattern words feed serializer input
// - pattern mode ignores parallel transmit bus
// - pass results readable in register
// - five-terminal boundary-scan port provided
// - pass flags read-only, H..A, reset zero
// - global bit enables pattern verification
// - global bit enables pattern generation
module loopback_prbs_test #(
    parameter int POR_HOLD = loopback_prbs_pkg::POR_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic loopback_all_pin,
    input wire logic pattern_test_pin,
    input wire logic [loopback_prbs_pkg::CHANNELS*loopback_prbs_pkg::WORD_W-1:0] tx_parallel_bus,
    input wire logic [loopback_prbs_pkg::CHANNELS*loopback_prbs_pkg::WORD_W-1:0] serial_rx_word,
    output logic [loopback_prbs_pkg::CHANNELS*loopback_prbs_pkg::WORD_W-1:0] serial_tx_word,
    output logic [loopback_prbs_pkg::CHANNELS-1:0] serial_tx_static,
    output loopback_prbs_pkg::par_out_t [loopback_prbs_pkg::CHANNELS-1:0] receive_parallel_bus,
    output logic por_active,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import loopback_prbs_pkg::*;

    localparam int N = CHANNELS;
    localparam int W = WORD_W;

    initial begin
        if (N != 8) $error("channel count must be 8");
        if (POR_HOLD < 1 || POR_HOLD >= (1 << 24)) $error("POR_HOLD out of range");
    end

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAUSE_DR,
        TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAUSE_IR,
        TAP_EX2_IR, TAP_UPD_IR
    } tap_t;

    typedef struct packed {
        logic [15:0] loopback;
        logic [15:0] global_ctl;
        logic [23:0] por_cnt;
        logic por;
        logic wr_addr_ok;
        logic wr_data_ok;
        logic [7:0] wr_addr;
        logic [31:0] wr_data;
        logic [3:0] wr_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awready, wready, arready;
        logic pin_lb_s1;
        logic pin_lb_s2;
        logic pin_pt_s1;
        logic pin_pt_s2;
        logic [2:0] tck_s;
        logic tms_s1;
        logic tms_s2;
        logic tdi_s1;
        logic tdi_s2;
        logic trst_s1;
        logic trst_s2;
        tap_t tap;
        logic [3:0] ir;
        logic [3:0] ir_sh;
        logic [31:0] dr_sh;
        logic bypass;
        logic tdo;
        logic tdo_oe;
        logic [N*W-1:0] ser_tx;
        logic [N-1:0] tx_static;
        par_out_t [N-1:0] rx_par;
    } state_t;

    state_t state_reg, state_next;

    logic [N*W-1:0] gen_words;
    logic [N-1:0] pass_flags;
    logic [N-1:0] slb;
    logic [N-1:0] far;
    logic pattern_on;
    logic verify_on;
    logic [N*W-1:0] rx_feed;

    // register read decode, also used by the boundary-scan id path
    function automatic logic [31:0] reg_read(input logic [7:0] a, input state_t s,
                                             input logic [N-1:0] p);
        case (a)
            ADDR_LOOPBACK: reg_read = {16'h0000, s.loopback};
            ADDR_GLOBAL: reg_read = {16'h0000, s.global_ctl};
            ADDR_PASS: reg_read = {16'h0000, p, 8'h00};
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == ADDR_LOOPBACK) || (a == ADDR_GLOBAL) || (a == ADDR_PASS);
    endfunction

    always_comb begin
        // pin level or register bit, either turns the mode on
        slb = state_reg.loopback[SLB_LSB +: N] | {N{state_reg.pin_lb_s2}};
        // far-end bits act in pairs: either bit of a pair loops both channels
        for (int c = 0; c < N; c++) begin
            far[c] = state_reg.loopback[FAR_LSB + (c & ~1)]
                   | state_reg.loopback[FAR_LSB + (c | 1)];
        end
        pattern_on = state_reg.pin_pt_s2 | state_reg.global_ctl[GEN_BIT];
        verify_on = pattern_on | state_reg.global_ctl[VERIFY_BIT];
        for (int c = 0; c < N; c++) begin
            // serial loopback replaces the line input with the own transmit word
            rx_feed[c*W +: W] = slb[c] ? state_reg.ser_tx[c*W +: W]
                                       : serial_rx_word[c*W +: W];
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chan
            pattern_channel #(.GOOD_RUN(LOCK_GOOD)) u_chan (
                .clk(clk),
                .reset_n(reset_n),
                .ce(ce),
                .gen_en(pattern_on),
                .chk_en(verify_on),
                .rx_word(rx_feed[g*W +: W]),
                .gen_word(gen_words[g*W +: W]),
                .pass(pass_flags[g])
            );
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        state_next.pin_lb_s1 = loopback_all_pin;
        state_next.pin_lb_s2 = state_reg.pin_lb_s1;
        state_next.pin_pt_s1 = pattern_test_pin;
        state_next.pin_pt_s2 = state_reg.pin_pt_s1;
        state_next.tck_s = {state_reg.tck_s[1:0], tck};
        state_next.tms_s1 = tms;
        state_next.tms_s2 = state_reg.tms_s1;
        state_next.tdi_s1 = tdi;
        state_next.tdi_s2 = state_reg.tdi_s1;
        state_next.trst_s1 = trst_n;
        state_next.trst_s2 = state_reg.trst_s1;

        // power-on hold counts up from zero to POR_HOLD - 1, then releases
        if (state_reg.por) begin
            if (state_reg.por_cnt == 24'(POR_HOLD - 1)) begin
                state_next.por = 1'b0;
            end else begin
                state_next.por_cnt = state_reg.por_cnt + 24'h000001;
            end
        end

        // transmit path per channel
        for (int c = 0; c < N; c++) begin
            if (far[c]) begin
                state_next.ser_tx[c*W +: W] = serial_rx_word[c*W +: W];
            end else if (pattern_on) begin
                state_next.ser_tx[c*W +: W] = gen_words[c*W +: W];
            end else begin
                state_next.ser_tx[c*W +: W] = tx_parallel_bus[c*W +: W];
            end
            state_next.tx_static[c] = slb[c] & ~far[c];
            state_next.rx_par[c].data = rx_feed[c*W +: W];
            state_next.rx_par[c].clk_out = ~state_reg.rx_par[c].clk_out;
            state_next.rx_par[c].oe = ~far[c];
            if (state_reg.por) begin
                state_next.rx_par[c].oe = 1'b0;
                state_next.rx_par[c].clk_out = 1'b0;
            end
        end

        // write channel: address and data taken in either order
        if (s_axi_awvalid && !state_reg.wr_addr_ok && !state_reg.bvalid) begin
            state_next.wr_addr_ok = 1'b1;
            state_next.wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.wr_data_ok && !state_reg.bvalid) begin
            state_next.wr_data_ok = 1'b1;
            state_next.wr_data = s_axi_wdata;
            state_next.wr_strb = s_axi_wstrb;
        end
        if (state_reg.wr_addr_ok && state_reg.wr_data_ok) begin
            state_next.wr_addr_ok = 1'b0;
            state_next.wr_data_ok = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = addr_ok(state_reg.wr_addr) ? RESP_OKAY : RESP_SLVERR;
            for (int b = 0; b < 2; b++) begin
                if (state_reg.wr_strb[b]) begin
                    if (state_reg.wr_addr == ADDR_LOOPBACK) begin
                        state_next.loopback[b*8 +: 8] = state_reg.wr_data[b*8 +: 8];
                    end
                    if (state_reg.wr_addr == ADDR_GLOBAL && b == 1) begin
                        state_next.global_ctl[GEN_BIT +: 2] = state_reg.wr_data[GEN_BIT +: 2];
                    end
                end
            end
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !state_reg.rvalid) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = reg_read(s_axi_araddr, state_reg, pass_flags);
            state_next.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        state_next.awready = !state_next.wr_addr_ok && !state_next.bvalid;
        state_next.wready = !state_next.wr_data_ok && !state_next.bvalid;
        state_next.arready = !state_next.rvalid;

        // boundary-scan port, sampled on rising tck; bypass and an id capture only
        if (!state_reg.trst_s2) begin
            state_next.tap = TAP_RESET;
            state_next.ir = 4'h1;
            state_next.tdo_oe = 1'b0;
        end else if (state_reg.tck_s[2:1] == 2'b01) begin
            case (state_reg.tap)
                TAP_RESET: state_next.tap = state_reg.tms_s2 ? TAP_RESET : TAP_IDLE;
                TAP_IDLE: state_next.tap = state_reg.tms_s2 ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: state_next.tap = state_reg.tms_s2 ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: state_next.tap = state_reg.tms_s2 ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR: state_next.tap = state_reg.tms_s2 ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: state_next.tap = state_reg.tms_s2 ? TAP_UPD_DR : TAP_PAUSE_DR;
                TAP_PAUSE_DR: state_next.tap = state_reg.tms_s2 ? TAP_EX2_DR : TAP_PAUSE_DR;
                TAP_EX2_DR: state_next.tap = state_reg.tms_s2 ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: state_next.tap = state_reg.tms_s2 ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: state_next.tap = state_reg.tms_s2 ? TAP_RESET : TAP_CAP_IR;
                TAP_CAP_IR: state_next.tap = state_reg.tms_s2 ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR: state_next.tap = state_reg.tms_s2 ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: state_next.tap = state_reg.tms_s2 ? TAP_UPD_IR : TAP_PAUSE_IR;
                TAP_PAUSE_IR: state_next.tap = state_reg.tms_s2 ? TAP_EX2_IR : TAP_PAUSE_IR;
                TAP_EX2_IR: state_next.tap = state_reg.tms_s2 ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: state_next.tap = state_reg.tms_s2 ? TAP_SEL_DR : TAP_IDLE;
                default: state_next.tap = TAP_RESET;
            endcase
            case (state_reg.tap)
                TAP_RESET: state_next.ir = 4'h1;
                TAP_CAP_IR: state_next.ir_sh = 4'h1;
                TAP_SH_IR: state_next.ir_sh = {state_reg.tdi_s2, state_reg.ir_sh[3:1]};
                TAP_UPD_IR: state_next.ir = state_reg.ir_sh;
                TAP_CAP_DR: begin
                    state_next.bypass = 1'b0;
                    // id code 1: pass flags word; other codes act as bypass
                    state_next.dr_sh = reg_read(ADDR_PASS, state_reg, pass_flags);
                end
                TAP_SH_DR: begin
                    state_next.bypass = state_reg.tdi_s2;
                    state_next.dr_sh = {state_reg.tdi_s2, state_reg.dr_sh[31:1]};
                end
                default: state_next.ir = state_reg.ir;
            endcase
        end else if (state_reg.tck_s[2:1] == 2'b10) begin
            // tdo changes on falling tck
            state_next.tdo_oe = (state_reg.tap == TAP_SH_DR) || (state_reg.tap == TAP_SH_IR);
            if (state_reg.tap == TAP_SH_IR) begin
                state_next.tdo = state_reg.ir_sh[0];
            end else if (state_reg.ir == 4'h1) begin
                state_next.tdo = state_reg.dr_sh[0];
            end else begin
                state_next.tdo = state_reg.bypass;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.loopback <= LOOPBACK_RESET;
            state_reg.global_ctl <= GLOBAL_RESET;
            state_reg.por <= 1'b1;
            state_reg.tap <= TAP_RESET;
            state_reg.ir <= 4'h1;
            state_reg.trst_s1 <= 1'b1;
            state_reg.trst_s2 <= 1'b1;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign serial_tx_word = state_reg.ser_tx;
    assign serial_tx_static = state_reg.tx_static;
    assign receive_parallel_bus = state_reg.rx_par;
    assign por_active = state_reg.por;
    assign tdo = state_reg.tdo;
    assign tdo_oe = state_reg.tdo_oe;
    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    por_float_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && state_reg.por |=> !receive_parallel_bus[0].oe && !receive_parallel_bus[0].clk_out)
        else $error("outputs not quiet during power-on hold");
    por_length_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(state_reg.por) |-> $past(state_reg.por_cnt) == 24'(POR_HOLD - 1))
        else $error("power-on hold ended early");
    far_float_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && far[0] |=> !receive_parallel_bus[0].oe)
        else $error("parallel outputs driven in far-end loopback");
    far_echo_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && far[1] |=> serial_tx_word[W +: W] == $past(serial_rx_word[W +: W]))
        else $error("far-end loopback not echoing");
    tx_static_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && slb[3] && !far[3] |=> serial_tx_static[3])
        else $error("transmit not static in serial loopback");
    pin_loop_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && state_reg.pin_lb_s2
        |=> receive_parallel_bus[5].data == $past(serial_tx_word[5*W +: W]))
        else $error("loopback pin missed a channel");
    pattern_tx_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && pattern_on && !far[0] |=> serial_tx_word[0 +: W] == $past(gen_words[0 +: W]))
        else $error("transmit not carrying pattern");
    pass_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && s_axi_arvalid && !state_reg.rvalid && s_axi_araddr == ADDR_PASS
        |=> s_axi_rvalid && s_axi_rdata[RX_PASS_LSB +: N] == $past(pass_flags))
        else $error("pass flags read wrong");
endmodule // loopback_prbs_test
`default_nettype wire

//--- logic/pattern_channel.sv
`timescale 1ns/1ns
`default_nettype none
module pattern_channel #(
    parameter int GOOD_RUN = loopback_prbs_pkg::LOCK_GOOD
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic gen_en,
    input wire logic chk_en,
    input wire logic [loopback_prbs_pkg::WORD_W-1:0] rx_word,
    output logic [loopback_prbs_pkg::WORD_W-1:0] gen_word,
    output logic pass
);
    import loopback_prbs_pkg::*;

    initial begin
        if (GOOD_RUN < 1 || GOOD_RUN > 255) $error("GOOD_RUN out of range");
    end

    typedef struct packed {
        logic [LFSR_W-1:0] gen;
        logic [LFSR_W-1:0] chk;
        logic [7:0] good;
        logic pass;
    } state_t;

    state_t state_reg, state_next;

    // advance a seven-stage register by one word of bits, msb first
    function automatic logic [LFSR_W+WORD_W-1:0] step(input logic [LFSR_W-1:0] s);
        logic [LFSR_W-1:0] t;
        logic [WORD_W-1:0] w;
        t = s;
        w = '0;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            w[i] = t[TAP_HI] ^ t[TAP_LO];
            t = {t[LFSR_W-2:0], w[i]};
        end
        return {t, w};
    endfunction

    logic [LFSR_W+WORD_W-1:0] g_step, c_step;
    logic [LFSR_W-1:0] seeded;
    logic match;

    always_comb begin
        g_step = step(state_reg.gen);
        c_step = step(state_reg.chk);
        // self-synchronise: last seven received bits become the checker state
        seeded = rx_word[LFSR_W-1:0];
        match = (c_step[WORD_W-1:0] == rx_word);
        state_next = state_reg;
        if (gen_en) begin
            state_next.gen = g_step[LFSR_W+WORD_W-1:WORD_W];
        end
        if (chk_en) begin
            state_next.chk = seeded;
            if (!match) begin
                state_next.good = '0;
            end else if (state_reg.good != 8'(GOOD_RUN)) begin
                state_next.good = state_reg.good + 8'h01;
            end
        end else begin
            state_next.good = '0;
        end
        state_next.pass = chk_en && match && (state_reg.good == 8'(GOOD_RUN));
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '{gen: LFSR_SEED, chk: LFSR_SEED, good: 8'h00, pass: 1'b0};
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign gen_word = g_step[WORD_W-1:0];
    assign pass = state_reg.pass;

    pass_needs_run_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg.pass |-> $past(state_reg.good) == 8'(GOOD_RUN))
        else $error("pass flag without full error-free run");
    pass_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !chk_en |=> !state_reg.pass)
        else $error("pass flag held while checker off");
endmodule // pattern_channel
`default_nettype wire

//--- tb/link_partner.sv
`timescale 1ns/1ns
`default_nettype none
module link_partner (
    input wire logic clk,
    input wire logic [1:0] mode,
    input wire logic [loopback_prbs_pkg::CHANNELS*loopback_prbs_pkg::WORD_W-1:0] tx_word,
    output logic [loopback_prbs_pkg::CHANNELS*loopback_prbs_pkg::WORD_W-1:0] rx_word
);
    import loopback_prbs_pkg::*;
    logic [CHANNELS*WORD_W-1:0] noise_reg;
    initial noise_reg = '0;
    initial rx_word = '0;
    // noise changes every cycle so a stale word never passes for a good one
    always @(posedge clk) begin
        noise_reg <= noise_reg + 80'h1F3;
        case (mode)
            2'h0: rx_word <= tx_word;
            2'h2: rx_word <= tx_word ^ 80'h1;
            default: rx_word <= noise_reg;
        endcase
    end
endmodule // link_partner
`default_nettype wire

//--- tb/transceiver_loopback_prbs_test_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module transceiver_loopback_prbs_test_tb_top;
    import loopback_prbs_pkg::*;
    localparam int W = CHANNELS * WORD_W;
    localparam int HOLD = 20;
    logic clk = 1'b0, reset_n = 1'b0, lb_pin = 1'b0, pt_pin = 1'b0;
    logic [W-1:0] tx_bus = '0;
    logic [W-1:0] rx_word, tx_word, prev;
    logic [CHANNELS-1:0] tx_static;
    par_out_t [CHANNELS-1:0] rx_bus;
    logic por;
    logic ce = 1'b1, tck = 1'b0, tms = 1'b1, tdi = 1'b0, trst_n = 1'b0, tdo, tdo_oe;
    logic [1:0] pmode = 2'h1;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    int err_count = 0, compares = 0;

    loopback_prbs_test #(.POR_HOLD(HOLD)) dut (.clk(clk), .reset_n(reset_n), .ce(ce),
        .loopback_all_pin(lb_pin), .pattern_test_pin(pt_pin), .tx_parallel_bus(tx_bus),
        .serial_rx_word(rx_word), .serial_tx_word(tx_word), .serial_tx_static(tx_static),
        .receive_parallel_bus(rx_bus), .por_active(por), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    link_partner partner (.clk(clk), .mode(pmode), .tx_word(tx_word), .rx_word(rx_word));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // msb leaves first, so the earliest bit of the pair sits at s[19]
    task automatic chk_prbs(input logic [19:0] s);
        int bad = 0;
        for (int n = 7; n < 20; n++) if (s[19-n] !== (s[26-n] ^ s[25-n])) bad++;
        chk(bad, 0);
    endtask

    task automatic t_por();
        repeat (2) @(posedge clk);
        chk(por, 1'b1);
        for (int c = 0; c < CHANNELS; c++) chk({rx_bus[c].oe, rx_bus[c].clk_out}, 2'h0);
        repeat (HOLD + 3) @(posedge clk);
        chk(por, 1'b0);
        rd_reg(ADDR_LOOPBACK);
        chk(rd[15:0], LOOPBACK_RESET);
        rd_reg(ADDR_GLOBAL);
        chk(rd[15:0], GLOBAL_RESET);
        rd_reg(ADDR_PASS);
        chk(rd[15:8], 8'h00);
        rd_reg(8'h10);
        chk(rs, RESP_SLVERR);
        $display("test por done");
    endtask

    task automatic t_loop();
        tx_bus <= {CHANNELS{10'h2B5}};
        wr(ADDR_LOOPBACK, 32'h100);
        repeat (8) @(posedge clk);
        chk(tx_static, 8'h01);
        chk(rx_bus[0].data, 10'h2B5);
        wr(ADDR_LOOPBACK, 32'h0);
        lb_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk(tx_static, 8'hFF);
        chk(rx_bus[7].data, 10'h2B5);
        lb_pin <= 1'b0;
        wr(ADDR_LOOPBACK, 32'h1);
        repeat (8) @(posedge clk);
        chk({rx_bus[1].oe, rx_bus[0].oe, rx_bus[2].oe}, 3'h1);
        prev = rx_word;
        @(posedge clk);
        chk(tx_word[19:0], prev[19:0]);
        // line noise moves every cycle, so only a frozen block keeps the echo still
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        prev = tx_word;
        repeat (3) @(posedge clk);
        chk(tx_word[19:0], prev[19:0]);
        ce <= 1'b1;
        wr(ADDR_LOOPBACK, 32'h0);
        $display("test loopback done");
    endtask

    // receive bus is never judged while the pattern pin is high
    task automatic t_pattern();
        pmode <= 2'h0;
        pt_pin <= 1'b1;
        repeat (10) @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            prev = tx_word;
            tx_bus <= ~tx_bus;
            @(posedge clk);
            for (int c = 0; c < CHANNELS; c++)
                chk_prbs({prev[c*WORD_W+:WORD_W], tx_word[c*WORD_W+:WORD_W]});
        end
        repeat (60) @(posedge clk);
        rd_reg(ADDR_PASS);
        chk(rd[15:8], 8'hFF);
        wr(ADDR_PASS, 32'h0);
        chk(rs, RESP_OKAY);
        rd_reg(ADDR_PASS);
        chk(rd[15:8], 8'hFF);
        pmode <= 2'h2;
        repeat (8) @(posedge clk);
        rd_reg(ADDR_PASS);
        chk(rd[15:8], 8'hFE);
        pmode <= 2'h0;
        pt_pin <= 1'b0;
        wr(ADDR_GLOBAL, 32'h300);
        rd_reg(ADDR_GLOBAL);
        chk(rd[15:0], 16'h0300);
        repeat (60) @(posedge clk);
        rd_reg(ADDR_PASS);
        chk(rd[15:8], 8'hFF);
        $display("test pattern done");
    endtask

    // one slow tck period, well above the three-flop detection lag
    task automatic tck_cyc(input logic m);
        tms <= m;
        repeat (4) @(posedge clk);
        tck <= 1'b1;
        repeat (4) @(posedge clk);
        tck <= 1'b0;
    endtask

    // default instruction captures the pass word; all channels pass by now
    task automatic t_scan();
        logic [15:0] got;
        trst_n <= 1'b1;
        tck_cyc(1'b0);
        tck_cyc(1'b1);
        tck_cyc(1'b0);
        tck_cyc(1'b0);
        for (int i = 0; i < 16; i++) begin
            repeat (4) @(posedge clk);
            got[i] = tdo;
            tck_cyc(1'b0);
        end
        chk(tdo_oe, 1'b1);
        chk(got, 16'hFF00);
        $display("test scan done");
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        t_por();
        t_loop();
        t_pattern();
        t_scan();
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        print_verdict();
    end
endmodule // transceiver_loopback_prbs_test_tb_top
`default_nettype wire
